// [rdbd_dma.sv]
// rdbd_dma.sv: ring descriptor and buffer bus-master dma sequencer
// Notes on behaviour
// - status byte check, then separate pointer read
// - chained non-last descriptors get single status write
// - tx dual write only on error, last
// - rx last descriptor gets dual status/length write
// - reads enable all lanes; writes only needed
// - descriptor words never swapped, bit 31 msb
// - buffer data moves in burst cycles
// - extended burst clear: at most four cycles
// - extended burst set: run to fifo threshold
// - two-wire grant drop preempts after current cycle
// - first buffer cycle reaches long-word alignment
// - short tail uses matching lanes, addresses ascend
// - buffer bytes swapped to target, ascending order
// - packet length, low 12 bits, written on last rx descriptor
// - bus cycle four clocks, stretched until ready
// - separate inbound and outbound transceiver enables
// - read: address, strobe, float, capture on ready
// - write: data after address strobe, held after
// - dual transfer is never preempted
`default_nettype none

module rdbd_dma
    import rdbd_pkg::*;
#(
    parameter int DEPTH  = FIFO_DEPTH,
    parameter int HI_THR = FIFO_DEPTH,
    parameter int LO_THR = 0
) (
    input  wire logic         ref_clk,
    input  wire logic         arst_n,
    input  wire logic         extended_burst_select,
    input  wire logic         two_wire_mode,
    input  wire logic         big_endian_target,
    input  wire logic         cmd_valid,
    output logic              cmd_ready,
    input  wire rdbd_op_type  cmd_op,
    input  wire logic [31:0]  cmd_addr,
    input  wire logic [31:0]  cmd_addr2,
    input  wire logic [15:0]  cmd_len,
    input  wire logic [7:0]   cmd_status,
    input  wire logic [31:0]  cmd_word2,
    input  wire logic         cmd_last,
    input  wire logic         cmd_rx,
    input  wire logic         cmd_error,
    output logic              done,
    output logic [31:0]       rd_data,
    output logic [31:0]       cur_addr,
    output logic [15:0]       bytes_left,
    output logic              preempted,
    input  wire logic         rx_byte_valid,
    output logic              rx_byte_ready,
    input  wire logic [7:0]   rx_byte,
    output logic              tx_byte_valid,
    input  wire logic         tx_byte_ready,
    output logic [7:0]        tx_byte,
    output logic              hold_req,
    input  wire logic         bus_grant_in,
    output logic [31:0]       ad_out,
    output logic              ad_oe,
    input  wire logic [31:0]  ad_in,
    output logic              address_latch_strobe,
    output logic              data_strobe_n,
    output logic              read_not_write,
    output logic [3:0]        byte_lane_enables_n,
    output logic              transfer_size_code_low,
    output logic              transfer_size_code_high,
    output logic [1:0]        addr_low,
    output logic              inbound_transceiver_enable,
    output logic              outbound_transceiver_enable,
    input  wire logic         cycle_ready_in_n
);
    localparam int LW      = $clog2(DEPTH + 1);
    localparam int MIN_CYC = MIN_CYC_CLKS;

    rdbd_state_type st_r;
    rdbd_state_type st_nxt;
    rdbd_op_type    op_r;
    logic [31:0]    addr_r;
    logic [31:0]    addr2_r;
    logic [31:0]    wdat_r;
    logic [31:0]    wd2_r;
    logic [31:0]    rdat_r;
    logic [15:0]    left_r;
    logic [3:0]     cyc_r;
    logic [3:0]     clen_r;
    logic [2:0]     bidx_r;
    logic           wsel_r;
    logic           dual_r;
    logic           dir_r;
    logic           preempt_r;

    logic           is_buf;
    logic           is_rd;
    logic           in_cyc;
    logic           drv_data;
    logic           preempt_now;
    logic           limit_ok;
    logic           can_go;
    logic           more;
    logic           adv;
    logic           last_b;
    logic           accept;
    logic [1:0]     off;
    logic [1:0]     moff;
    logic [1:0]     ln;
    logic [1:0]     siz;
    logic [2:0]     room;
    logic [2:0]     nb;
    logic [3:0]     in_rng;
    logic [3:0]     mask_le;
    logic [3:0]     mask_be;
    logic [3:0]     lanes;
    logic [7:0]     st_byte;
    logic [LW-1:0]  lvl;

    // ************************************************************
    // decode of the current transfer
    // ************************************************************
    assign accept   = (st_r == S_IDLE) && cmd_valid;
    assign is_buf   = (op_r == OP_BUF_TX) || (op_r == OP_BUF_RX);
    assign is_rd    = (op_r != OP_DESC_UPD) && (op_r != OP_BUF_RX);
    assign in_cyc   = (st_r == S_ADDR) || (st_r == S_STRB)
                   || (st_r == S_WAIT) || (st_r == S_FIN);
    assign drv_data = !is_rd && in_cyc && (st_r != S_ADDR);
    assign off      = addr_r[1:0];
    assign room     = 3'h4 - {1'b0, off};
    assign nb       = !is_buf ? 3'h4
                    : (left_r < 16'(room)) ? left_r[2:0]
                    : room;
    assign moff     = off + bidx_r[1:0];
    assign ln       = big_endian_target ? ~moff : moff;
    assign last_b   = (bidx_r == nb - 3'h1);

    // ************************************************************
    // byte lanes
    // ************************************************************
    for (genvar k = 0; k < 4; k++) begin : g_lane
        assign in_rng[k]      = (3'(k) >= {1'b0, off})
                             && (3'(k) < ({1'b0, off} + nb));
        assign mask_le[k]     = in_rng[k];
        assign mask_be[3 - k] = in_rng[k];
    end

    assign lanes = is_rd ? LANES_ALL
                 : is_buf ? (big_endian_target ? mask_be : mask_le)
                 : wsel_r ? LANES_ALL
                 : LANES_STATUS;

    // ************************************************************
    // fifo between bus and network byte streams
    // ************************************************************
    rdbd_fifo_if #(.W(FIFO_WIDTH), .DEPTH(DEPTH)) fq ();

    assign fq.in_valid   = dir_r ? rx_byte_valid : (st_r == S_UNLD);
    assign fq.in_data    = dir_r ? rx_byte : rdat_r[{ln, 3'h0} +: 8];
    assign fq.out_ready  = dir_r ? (st_r == S_LOAD) : tx_byte_ready;
    assign rx_byte_ready = dir_r && fq.in_ready;
    assign tx_byte_valid = !dir_r && fq.out_valid;
    assign tx_byte       = fq.out_data;
    assign lvl           = fq.level;

    rdbd_fifo #(
        .W     (FIFO_WIDTH),
        .DEPTH (DEPTH)
    ) u_fifo (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .f       (fq.fifo)
    );

    // ************************************************************
    // burst continuation
    // ************************************************************
    assign preempt_now = two_wire_mode && !bus_grant_in;
    assign limit_ok    = extended_burst_select
                      || (cyc_r < 4'(BURST_MAX));
    assign can_go = (op_r == OP_BUF_TX)
        ? (int'(lvl) + int'(nb)
           <= (extended_burst_select ? HI_THR : DEPTH))
        : (int'(lvl)
           >= int'(nb) + (extended_burst_select ? LO_THR : 0));
    assign more = (left_r != 16'h0) && limit_ok
               && can_go && !preempt_now;
    assign adv  = ((st_r == S_FIN) && (op_r != OP_BUF_TX))
               || ((st_r == S_UNLD) && last_b);
    assign st_byte = cmd_last ? (cmd_status | ENP_MASK)
                   : (cmd_status & ~ENP_MASK);

    // ************************************************************
    // sequencer
    // ************************************************************
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            S_IDLE: begin
                if (cmd_valid)
                    st_nxt = S_REQ;
            end
            S_REQ: begin
                if (bus_grant_in) begin
                    if (!is_buf)
                        st_nxt = S_ADDR;
                    else if (!more)
                        st_nxt = S_DONE;
                    else if (op_r == OP_BUF_RX)
                        st_nxt = S_LOAD;
                    else
                        st_nxt = S_ADDR;
                end
            end
            S_ADDR: st_nxt = S_STRB;
            S_STRB: st_nxt = S_WAIT;
            S_WAIT: begin
                if (!cycle_ready_in_n)
                    st_nxt = S_FIN;
            end
            S_FIN: begin
                if (op_r == OP_BUF_TX)
                    st_nxt = S_UNLD;
                else
                    st_nxt = S_NEXT;
            end
            S_UNLD: begin
                if (last_b)
                    st_nxt = S_NEXT;
            end
            S_LOAD: begin
                if (last_b)
                    st_nxt = S_ADDR;
            end
            S_NEXT: begin
                if (is_buf) begin
                    if (!more)
                        st_nxt = S_DONE;
                    else if (op_r == OP_BUF_RX)
                        st_nxt = S_LOAD;
                    else
                        st_nxt = S_ADDR;
                end else if (dual_r && !wsel_r) begin
                    st_nxt = S_ADDR;
                end else begin
                    st_nxt = S_DONE;
                end
            end
            S_DONE: st_nxt = S_IDLE;
            default: st_nxt = S_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n)
            st_r <= S_IDLE;
        else
            st_r <= st_nxt;
    end

    // ************************************************************
    // command capture and descriptor words
    // ************************************************************
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            op_r    <= OP_RD_STATUS;
            addr2_r <= 32'h0;
            dual_r  <= 1'b0;
            wd2_r   <= 32'h0;
            dir_r   <= 1'b0;
        end else if (accept) begin
            op_r    <= cmd_op;
            addr2_r <= cmd_addr2;
            dual_r  <= cmd_last && (cmd_rx || cmd_error);
            wd2_r   <= cmd_rx ? {cmd_word2[31:LEN_W],
                                 cmd_len[LEN_W-1:0]}
                              : cmd_word2;
            if ((cmd_op == OP_BUF_TX) || (cmd_op == OP_BUF_RX))
                dir_r <= (cmd_op == OP_BUF_RX);
        end
    end

    // ************************************************************
    // address, count and write data
    // ************************************************************
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            addr_r <= 32'h0;
            left_r <= 16'h0;
            wdat_r <= 32'h0;
            wsel_r <= 1'b0;
        end else if (accept) begin
            addr_r <= cmd_addr;
            left_r <= cmd_len;
            wdat_r <= {st_byte, 24'h0};
            wsel_r <= 1'b0;
        end else if ((st_r == S_NEXT) && !is_buf
                     && dual_r && !wsel_r) begin
            addr_r <= addr2_r;
            wdat_r <= wd2_r;
            wsel_r <= 1'b1;
        end else if (adv && is_buf) begin
            addr_r <= addr_r + 32'(nb);
            left_r <= left_r - 16'(nb);
        end else if (st_r == S_LOAD) begin
            wdat_r[{ln, 3'h0} +: 8] <= fq.out_data;
        end
    end

    // ************************************************************
    // read capture, counters and preemption flag
    // ************************************************************
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n)
            rdat_r <= 32'h0;
        else if ((st_r == S_WAIT) && !cycle_ready_in_n)
            rdat_r <= ad_in;
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cyc_r     <= 4'h0;
            bidx_r    <= 3'h0;
            preempt_r <= 1'b0;
        end else if (accept) begin
            cyc_r     <= 4'h0;
            bidx_r    <= 3'h0;
            preempt_r <= 1'b0;
        end else begin
            if (adv)
                cyc_r <= cyc_r + 4'h1;
            if ((st_r == S_LOAD) || (st_r == S_UNLD))
                bidx_r <= last_b ? 3'h0 : bidx_r + 3'h1;
            if ((st_r == S_NEXT) && is_buf
                && (left_r != 16'h0) && preempt_now)
                preempt_r <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n)
            clen_r <= 4'h0;
        else if (st_r == S_ADDR)
            clen_r <= 4'h1;
        else if (in_cyc && (clen_r != 4'hF))
            clen_r <= clen_r + 4'h1;
    end

    // ************************************************************
    // user-side outputs
    // ************************************************************
    assign cmd_ready  = (st_r == S_IDLE);
    assign done       = (st_r == S_DONE);
    assign rd_data    = rdat_r;
    assign cur_addr   = addr_r;
    assign bytes_left = left_r;
    assign preempted  = preempt_r;

    // ************************************************************
    // host bus pins
    // ************************************************************
    assign hold_req = (st_r != S_IDLE) && (st_r != S_DONE);
    assign address_latch_strobe = (st_r == S_ADDR);
    assign data_strobe_n  = !((st_r == S_STRB) || (st_r == S_WAIT));
    assign read_not_write = !in_cyc || is_rd;
    assign addr_low       = (in_cyc && !is_rd && is_buf) ? off : 2'h0;
    assign ad_oe          = (st_r == S_ADDR) || drv_data;
    assign ad_out = (st_r == S_ADDR)
        ? {addr_r[31:2], two_wire_mode ? 2'h0 : addr_low}
        : wdat_r;
    assign byte_lane_enables_n = in_cyc ? ~lanes : 4'hF;
    assign siz = (!in_cyc || is_rd) ? SIZE_LONG
               : is_buf ? nb[1:0]
               : wsel_r ? SIZE_LONG
               : SIZE_BYTE;
    assign transfer_size_code_low  = siz[0];
    assign transfer_size_code_high = siz[1];
    assign inbound_transceiver_enable = is_rd
        && ((st_r == S_STRB) || (st_r == S_WAIT));
    assign outbound_transceiver_enable = drv_data;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);

    sequence s_read_open;
        !ad_oe && !data_strobe_n && inbound_transceiver_enable;
    endsequence

    sequence s_cycle_head;
        (st_r == S_STRB) ##1 (st_r == S_WAIT);
    endsequence

    a_cycle_min_len: assert property (
        (st_r == S_FIN) |-> (clen_r >= 4'(MIN_CYC - 1)))
        else $error("bus cycle shorter than minimum");

    a_ready_stretch: assert property (
        (st_r == S_WAIT) && cycle_ready_in_n
        |=> (st_r == S_WAIT) && !data_strobe_n)
        else $error("cycle ended without ready");

    a_read_open: assert property (
        address_latch_strobe && read_not_write
        |=> s_read_open ##1 !data_strobe_n)
        else $error("read did not float bus and strobe");

    a_write_open: assert property (
        address_latch_strobe && !read_not_write
        |=> s_cycle_head and (ad_oe && !address_latch_strobe)[*2])
        else $error("write data not driven after address");

    a_read_lanes: assert property (
        !data_strobe_n && read_not_write
        |-> (byte_lane_enables_n == 4'h0))
        else $error("read without all lanes");

    a_xcvr_excl: assert property (
        inbound_transceiver_enable
        |-> !outbound_transceiver_enable && read_not_write)
        else $error("transceiver enables overlap");

    a_write_hold: assert property (
        $rose(data_strobe_n) && !read_not_write
        |-> ad_oe && outbound_transceiver_enable)
        else $error("write data dropped with strobe");

    a_burst_max: assert property (
        is_buf && !extended_burst_select && (st_r != S_IDLE)
        |-> (cyc_r <= 4'(BURST_MAX)))
        else $error("burst exceeded four cycles");

    a_status_lane: assert property (
        address_latch_strobe && (op_r == OP_DESC_UPD) && !wsel_r
        |-> (byte_lane_enables_n == 4'h7))
        else $error("status write touched other lanes");

    a_dual_keep: assert property (
        (st_r == S_NEXT) && (op_r == OP_DESC_UPD) && dual_r && !wsel_r
        |=> address_latch_strobe && hold_req)
        else $error("dual transfer released early");

    a_align_next: assert property (
        adv && is_buf && (left_r > 16'(nb))
        |=> (addr_r[1:0] == 2'h0))
        else $error("buffer cycle left misaligned");

    a_preempt_rel: assert property (
        (st_r == S_FIN) && is_buf && preempt_now && !$fell(bus_grant_in)
        |-> ##[1:8] !hold_req)
        else $error("preempted burst kept the bus");

endmodule

`default_nettype wire

// [rdbd_fifo.sv]
// rdbd_fifo.sv: flip-flop fifo with valid/ready on both sides
`default_nettype none

module rdbd_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 8
) (
    input  wire logic ref_clk,
    input  wire logic arst_n,
    rdbd_fifo_if.fifo f
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int LW = $clog2(DEPTH + 1);

    logic [W-1:0]  mem_r [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [LW-1:0] cnt_r;
    logic          push;
    logic          pop;

    // ************************************************************
    // handshake
    // ************************************************************
    assign f.in_ready  = (cnt_r != LW'(DEPTH));
    assign f.out_valid = (cnt_r != '0);
    assign f.out_data  = mem_r[rp_r];
    assign f.level     = cnt_r;
    assign push        = f.in_valid && f.in_ready;
    assign pop         = f.out_valid && f.out_ready;

    // ************************************************************
    // pointers and count
    // ************************************************************
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (push)
                wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + AW'(1);
            if (pop)
                rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + AW'(1);
            cnt_r <= cnt_r + LW'(push) - LW'(pop);
        end
    end

    // ************************************************************
    // storage
    // ************************************************************
    for (genvar e = 0; e < DEPTH; e++) begin : g_ent
        always_ff @(posedge ref_clk) begin
            if (push && (wp_r == AW'(e)))
                mem_r[e] <= f.in_data;
        end
    end

endmodule

`default_nettype wire

// [rdbd_fifo_if.sv]
// rdbd_fifo_if.sv: handshake bundle between the sequencer and its fifo
`default_nettype none

interface rdbd_fifo_if #(
    parameter int W     = 8,
    parameter int DEPTH = 8
);
    localparam int LW = $clog2(DEPTH + 1);

    logic          in_valid;
    logic          in_ready;
    logic [W-1:0]  in_data;
    logic          out_valid;
    logic          out_ready;
    logic [W-1:0]  out_data;
    logic [LW-1:0] level;

    modport fifo (
        input  in_valid, in_data, out_ready,
        output in_ready, out_valid, out_data, level
    );
    modport user (
        output in_valid, in_data, out_ready,
        input  in_ready, out_valid, out_data, level
    );
endinterface

`default_nettype wire

// [rdbd_mem.sv]
// rdbd_mem.sv: host memory and bus arbiter model
`default_nettype none
module rdbd_mem
    import rdbd_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        hold_req,
    input  wire logic        data_strobe_n,
    input  wire logic        address_latch_strobe,
    input  wire logic [31:0] ad_out,
    input  wire logic [1:0]  waits,
    input  wire logic        drop,
    output logic             bus_grant_in,
    output logic [31:0]      ad_in,
    output logic             cycle_ready_in_n
);
    logic [31:0] adr_r;
    logic [1:0]  cnt_r;
    wire  [31:0] word = {adr_r[15:0], ~adr_r[15:0]};
    // ready after the wait count; bus shows inverted junk otherwise
    assign cycle_ready_in_n = data_strobe_n || cnt_r != waits;
    assign ad_in = cycle_ready_in_n ? ~word : word;
    always @(posedge ref_clk) begin
        bus_grant_in <= hold_req && !drop;
        cnt_r <= data_strobe_n ? 2'h0 : cnt_r + 2'(cnt_r != waits);
        if (address_latch_strobe) adr_r <= {ad_out[31:2], 2'h0};
    end
endmodule
`default_nettype wire

// [rdbd_pkg.sv]
// rdbd_pkg.sv: constants and types of the ring descriptor/buffer dma
`default_nettype none

package rdbd_pkg;

    // ************************************************************
    // sizes and timing
    // ************************************************************
    localparam int         FIFO_DEPTH   = 8;
    localparam int         FIFO_WIDTH   = 8;
    localparam int         BURST_MAX    = 4;
    localparam int         BUS_CLK_NS   = 40;
    localparam int         MIN_CYC_NS   = 4 * BUS_CLK_NS;
    localparam int         MIN_CYC_CLKS = MIN_CYC_NS / BUS_CLK_NS;

    // ************************************************************
    // lanes, size codes and descriptor fields
    // ************************************************************
    localparam logic [3:0] LANES_ALL    = 4'hF;
    localparam logic [3:0] LANES_STATUS = 4'h8;
    localparam logic [1:0] SIZE_LONG    = 2'h0;
    localparam logic [1:0] SIZE_BYTE    = 2'h1;
    localparam logic [7:0] ENP_MASK     = 8'h01;
    localparam int         LEN_W        = 12;

    // ************************************************************
    // commands and states
    // ************************************************************
    typedef enum logic [2:0] {
        OP_RD_STATUS = 3'h0,
        OP_RD_PTR    = 3'h1,
        OP_DESC_UPD  = 3'h2,
        OP_BUF_TX    = 3'h3,
        OP_BUF_RX    = 3'h4
    } rdbd_op_type;

    typedef enum logic [9:0] {
        S_IDLE = 10'h001,
        S_REQ  = 10'h002,
        S_ADDR = 10'h004,
        S_STRB = 10'h008,
        S_WAIT = 10'h010,
        S_FIN  = 10'h020,
        S_LOAD = 10'h040,
        S_UNLD = 10'h080,
        S_NEXT = 10'h100,
        S_DONE = 10'h200
    } rdbd_state_type;

endpackage

`default_nettype wire

// [tb_top.sv]
// tb_top.sv: bench of the dma sequencer against the memory model
`default_nettype none
module tb_top
    import rdbd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    rdbd_op_type op = OP_RD_STATUS;
    logic ref_clk = 0, arst_n = 0, cv = 0, bet = 0, last = 0, rx = 0, er = 0;
    logic eb = 0, tw = 0, rxv = 0, drp = 0, pre, rxr;
    logic [7:0] rb = 0;
    logic [15:0] bl;
    logic [31:0] ca;
    logic [31:0] a1 = 0, a2 = 0, w2 = 32'hABCDE000, w, ad_out, ad_in, rd_data;
    logic [15:0] len = 0;
    logic [7:0] st = 8'h80, txb;
    logic [1:0] wt = 0;
    logic [3:0] be_n;
    logic done, txv, hold, gnt, ale, das_n, rnw, rdy_n;
    logic [36:0] wq[$];
    logic [29:0] aq[$];
    logic [7:0] bq[$];
    int error_cnt = 0, comparisons = 0, cyc = 0;
    always #20 ref_clk = ~ref_clk;
    rdbd_dma i_rdbd_dma (.ref_clk, .arst_n, .extended_burst_select(eb),
        .two_wire_mode(tw), .big_endian_target(bet), .cmd_valid(cv),
        .cmd_ready(), .cmd_op(op), .cmd_addr(a1), .cmd_addr2(a2),
        .cmd_len(len), .cmd_status(st), .cmd_word2(w2), .cmd_last(last),
        .cmd_rx(rx), .cmd_error(er), .done, .rd_data, .cur_addr(ca),
        .bytes_left(bl), .preempted(pre), .rx_byte_valid(rxv),
        .rx_byte_ready(rxr), .rx_byte(rb), .tx_byte_valid(txv),
        .tx_byte_ready(1'b1),
        .tx_byte(txb), .hold_req(hold), .bus_grant_in(gnt), .ad_out,
        .ad_oe(), .ad_in, .address_latch_strobe(ale), .data_strobe_n(das_n),
        .read_not_write(rnw), .byte_lane_enables_n(be_n),
        .transfer_size_code_low(), .transfer_size_code_high(), .addr_low(),
        .inbound_transceiver_enable(), .outbound_transceiver_enable(),
        .cycle_ready_in_n(rdy_n));
    rdbd_mem i_rdbd_mem (.ref_clk, .hold_req(hold), .data_strobe_n(das_n),
        .address_latch_strobe(ale), .ad_out, .waits(wt), .drop(drp),
        .bus_grant_in(gnt), .ad_in, .cycle_ready_in_n(rdy_n));
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [36:0] seen, input logic [36:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic run(input rdbd_op_type o, input logic [31:0] x, y,
                       input logic [15:0] n, input logic [2:0] q);
        @(posedge ref_clk);
        op <= o; a1 <= x; a2 <= y; len <= n; {last, rx, er} <= q; cv <= 1'b1;
        @(posedge ref_clk);
        cv <= 1'b0;
        wq.delete(); aq.delete(); bq.delete();
        repeat (80) begin
            @(negedge ref_clk);
            if (done === 1'b1) break;
        end
        chk(37'(done), 37'h1);
        repeat (12) @(posedge ref_clk);
        $display("test op %0d ended at %0t", o, $time);
    endtask
    task automatic upd(input logic [2:0] q, input logic [36:0] e2);
        run(OP_DESC_UPD, 32'h110, 32'h114, 16'h0123, q);
        chk(37'(wq.size()), e2 ? 37'h2 : 37'h1);
        chk(wq[0], {5'h07, q[2] ? 8'h81 : 8'h80, 24'h0});
        if (e2 != 0) chk(wq[1], e2);
    endtask
    // bus monitor and hang guard
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (ale) aq.push_back(ad_out[31:2]);
        if (!das_n && !rdy_n) wq.push_back({rnw, be_n, rnw ? ad_in : ad_out});
        if (txv) bq.push_back(txb);
        if (!hold) drp <= 1'b0;
        else if (tw && ale) drp <= 1'b1;
        if (rxr && rxv) rb <= rb + 8'h01;
        if (cyc == 2000) begin
            error_cnt++;
            give_verdict();
        end
    end
    initial begin
        repeat (6) @(posedge ref_clk);
        arst_n <= 1'b1;
        run(OP_RD_STATUS, 32'h100, 0, 0, 0);
        chk(wq[0], {5'h10, 32'h0100FEFF});
        wt <= 2'h2;
        run(OP_RD_PTR, 32'h104, 0, 0, 0);
        chk(37'(rd_data), 37'h0104FEFB);
        upd(3'b000, 0);
        upd(3'b110, {5'h0, 20'hABCDE, 12'h123});
        upd(3'b101, {5'h0, 32'hABCDE000});
        upd(3'b100, 0);
        for (int b = 0; b < 2; b++) begin
            bet <= b[0];
            run(OP_BUF_TX, 32'h202, 0, 16'h7, 0);
            chk(37'(aq.size()), 37'h3);
            chk(37'(ca), 37'h209);
            for (int i = 0; i < 3; i++) chk(37'(aq[i]), 37'(30'h80 + i));
            for (int i = 0; i < 7; i++) begin
                w = 32'h200 + 32'((i + 2) / 4 * 4);
                w = {w[15:0], ~w[15:0]} >> (8 * (b ? 3 - (i + 2) % 4 : (i + 2) % 4));
                chk(37'(bq[i]), 37'(w[7:0]));
            end
        end
        for (int e = 0; e < 3; e++) begin
            {tw, eb} <= 2'(e);
            run(OP_BUF_TX, 32'h200, 0, 16'd20, 0);
            chk(37'(aq.size()), e == 1 ? 37'h5 : e ? 37'h1 : 37'h4);
            chk(37'(bl), e == 1 ? 37'h0 : e ? 37'h10 : 37'h4);
            chk(37'(pre), 37'(e == 2));
        end
        {bet, tw} <= 2'b00;
        rxv <= 1'b1;
        run(OP_BUF_RX, 32'h302, 0, 16'h40, 0);
        chk(37'(aq.size()), 37'h0);
        chk(37'(bl), 37'h40);
        run(OP_BUF_RX, 32'h302, 0, 16'h40, 0);
        chk(37'(aq.size()), 37'h4);
        chk(37'(bl), 37'h32);
        chk(wq[0] & 37'h1FFFFF0000, {5'h03, 32'h01000000});
        chk(wq[1], {5'h00, 32'h05040302});
        give_verdict();
    end
endmodule
`default_nettype wire
